// ==== verilog/pmcf_pkg.sv ====
// Constants for the monitor filter and authentication status bank.
// Assumes a single 200 MHz clock and the external debug register port.
// What this block does
// - Mirror four noninvasive auth fields from debug status
// - Invasive auth fields always read zero
// - Auth status read-only when powered, else error
// - Auth status power domain follows feature presence
// - Bit 31 set blocks EL1 counting
// - Bit 30 set blocks EL0 counting
// - Nonsecure EL1 counts if bit 29 equals 31
// - Nonsecure EL0 counts if bit 28 equals 30
// - Bit 27 enables EL2 counting
// - EL3 counts when bit 26 matches bit 31
// - Secure EL2 counts if bits 24, 27 differ
// - Realm EL1 counts if bit 22 equals 31
// - Realm EL0 counts if bit 21 equals 30
// - Realm EL2 counts if bits 20, 27 differ
// - Reset clears filter for 32-bit, unknown otherwise
// - External debug reset leaves filter unchanged
// - Filter access by power, locks, permission, soft lock
package pmcf_pkg;
    // Register offsets
    localparam logic [11:0] CYCLE_COUNT_FILTER_OFS = 12'h47C;
    localparam logic [11:0] MONITOR_AUTH_STATUS_OFS = 12'hFB8;
    // Filter field positions
    localparam int EL1_EXCL_BIT = 31;
    localparam int EL0_EXCL_BIT = 30;
    localparam int NS_EL1_BIT = 29;
    localparam int NS_EL0_BIT = 28;
    localparam int EL2_EN_BIT = 27;
    localparam int EL3_BIT = 26;
    localparam int S_EL2_BIT = 24;
    localparam int RL_EL1_BIT = 22;
    localparam int RL_EL0_BIT = 21;
    localparam int RL_EL2_BIT = 20;
    // Value after reset of the filter
    localparam logic [31:0] FILTER_RESET_VAL = 32'h0000_0000;
    // Counter width
    localparam int CNT_W = 64;
    // Exception levels
    typedef enum logic [1:0] {
        PMCF_EL0 = 2'b00,
        PMCF_EL1 = 2'b01,
        PMCF_EL2 = 2'b10,
        PMCF_EL3 = 2'b11
    } pmcf_el_t;
    // Security states
    typedef enum logic [1:0] {
        PMCF_SEC = 2'b00,
        PMCF_NSEC = 2'b01,
        PMCF_ROOT = 2'b10,
        PMCF_REALM = 2'b11
    } pmcf_sec_t;
endpackage

// ==== verilog/pmcf_cycle_counter.sv ====
// Cycle counter that steps on every clock its enable is high.
// Assumes the enable comes from logic on the same clock.
module pmcf_cycle_counter #(
    parameter int W = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic count_en,
    output logic [W-1:0] count
);
    // Counter register
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    // Step when enabled
    assign nxt_count = count_en ? count_ff + {{(W-1){1'b0}}, 1'b1} : count_ff;

    // Count register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign count = count_ff;
endmodule

// ==== verilog/pmcf_regs.sv ====
// Filter register, authentication status and filtered cycle counter.
// Assumes the debug port, lock and power signals are on CLK; the
// debug authentication fields are pins and are synchronised here.
module pmcf_regs #(
    parameter bit HAS_EL2 = 1'b1,
    parameter bit HAS_EL3 = 1'b1,
    parameter bit HAS_SEL2 = 1'b1,
    parameter bit HAS_RME = 1'b1,
    parameter bit HAS_DOPD = 1'b1
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RST_32BIT,
    input wire logic EXT_DBG_RST,
    input wire logic CORE_POWERED,
    input wire logic DOUBLE_LOCK,
    input wire logic OS_LOCK,
    input wire logic EXT_ACCESS_OK,
    input wire logic SOFT_LOCK,
    input wire logic SEL2_ENABLED,
    input wire logic [1:0] ROOT_NONINVASIVE_FIELD,
    input wire logic [1:0] REALM_NONINVASIVE_FIELD,
    input wire logic [1:0] SECURE_NONINVASIVE_FIELD,
    input wire logic [1:0] NONSECURE_NONINVASIVE_FIELD,
    input wire pmcf_pkg::pmcf_el_t CUR_EL,
    input wire pmcf_pkg::pmcf_sec_t CUR_SEC,
    input wire logic DBG_SEL,
    input wire logic DBG_WR,
    input wire logic [11:0] DBG_ADDR,
    input wire logic [31:0] DBG_WDATA,
    output logic [31:0] DBG_RDATA,
    output logic DBG_ERR,
    output logic DBG_READY,
    output logic [pmcf_pkg::CNT_W-1:0] CYCLE_COUNTER
);
    import pmcf_pkg::*;

    // Writable mask built from features present
    localparam logic [31:0] WR_MASK = {2'b11, HAS_EL3, HAS_EL3, HAS_EL2, HAS_EL3, 1'b0,
        HAS_SEL2 & HAS_EL3, 1'b0, HAS_RME, HAS_RME, HAS_RME, 20'h00000};

    // Filter register
    logic [31:0] filter_ff;
    logic [31:0] nxt_filter;
    // Read answer registers
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic err_ff;
    logic nxt_err;
    logic ready_ff;
    // Two-stage synchronisers for auth field pins
    logic [7:0] auth_s1_ff;
    logic [7:0] auth_s2_ff;
    // Low only until the first edge after reset; read by the reset checks
    logic rst_seen_ff;

    // Address decode
    wire hit_filter = DBG_SEL && (DBG_ADDR == CYCLE_COUNT_FILTER_OFS);
    wire hit_auth = DBG_SEL && (DBG_ADDR == MONITOR_AUTH_STATUS_OFS);
    // Access conditions
    wire filter_open = CORE_POWERED && !DOUBLE_LOCK && !OS_LOCK && EXT_ACCESS_OK;
    wire filter_rw = filter_open && !SOFT_LOCK;
    wire auth_open = !HAS_DOPD || CORE_POWERED;
    wire filter_wr = hit_filter && DBG_WR && filter_rw;
    // Bits hidden from readers and from the verdicts while their feature is off
    wire [31:0] hide_mask = SEL2_ENABLED ? 32'h0000_0000 : 32'h0100_0000;
    // Secure EL2 bit reads zero when secure EL2 is disabled
    wire [31:0] filter_view = filter_ff & ~hide_mask;

    // Authentication status word
    wire [31:0] auth_word = {4'h0, auth_s2_ff[7:6], 2'b00, 8'h00, auth_s2_ff[5:4], 2'b00,
        4'h0, auth_s2_ff[3:2], 2'b00, auth_s2_ff[1:0], 2'b00};

    // Next filter value on a permitted write
    assign nxt_filter = filter_wr ? (DBG_WDATA & WR_MASK) : filter_ff;

    // Read data and error
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        if (hit_auth) begin
            // Auth is read-only; write ignored but no error when open
            nxt_err = !auth_open;
            nxt_rdata = auth_open ? auth_word : 32'h0000_0000;
        end else if (hit_filter) begin
            nxt_err = !filter_open;
            nxt_rdata = filter_open ? filter_view : 32'h0000_0000;
        end else if (DBG_SEL) begin
            nxt_err = 1'b1;
        end
    end

    // Per-level verdicts of the filter for the current state
    logic el1_ok; // EL1 may count
    logic el0_ok; // EL0 may count
    logic el2_ok; // EL2 may count
    logic el3_ok; // EL3 may count
    logic pass; // Current cycle may count
    // Filter as the counting logic sees it
    wire [31:0] f = filter_view;
    always_comb begin
        el1_ok = !f[EL1_EXCL_BIT];
        if (CUR_SEC == PMCF_NSEC && HAS_EL3) begin
            el1_ok = f[NS_EL1_BIT] == f[EL1_EXCL_BIT];
        end else if (CUR_SEC == PMCF_REALM && HAS_RME) begin
            el1_ok = f[RL_EL1_BIT] == f[EL1_EXCL_BIT];
        end
        el0_ok = !f[EL0_EXCL_BIT];
        if (CUR_SEC == PMCF_NSEC && HAS_EL3) begin
            el0_ok = f[NS_EL0_BIT] == f[EL0_EXCL_BIT];
        end else if (CUR_SEC == PMCF_REALM && HAS_RME) begin
            el0_ok = f[RL_EL0_BIT] == f[EL0_EXCL_BIT];
        end
        el2_ok = HAS_EL2 && f[EL2_EN_BIT];
        if (CUR_SEC == PMCF_SEC && HAS_SEL2 && HAS_EL3) begin
            el2_ok = f[S_EL2_BIT] != f[EL2_EN_BIT];
        end else if (CUR_SEC == PMCF_REALM && HAS_RME) begin
            el2_ok = f[RL_EL2_BIT] != f[EL2_EN_BIT];
        end
        el3_ok = HAS_EL3 && (f[EL3_BIT] == f[EL1_EXCL_BIT]);
        case (CUR_EL)
            PMCF_EL0: pass = el0_ok;
            PMCF_EL1: pass = el1_ok;
            PMCF_EL2: pass = el2_ok;
            default: pass = el3_ok;
        endcase
    end

    // Counter steps only on passing cycles
    pmcf_cycle_counter #(.W(CNT_W)) u_cnt (
        .clk(CLK),
        .rst_n(RST_N),
        .count_en(pass),
        .count(CYCLE_COUNTER)
    );

    // Filter storage; external debug reset does not touch it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            filter_ff <= FILTER_RESET_VAL;
        end else begin
            filter_ff <= nxt_filter;
        end
    end

    // First-edge marker: zero is a legal reset value for both reset targets
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_seen_ff <= 1'b0;
        end else begin
            rst_seen_ff <= 1'b1;
        end
    end

    // Auth pin synchronisers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            auth_s1_ff <= 8'h00;
            auth_s2_ff <= 8'h00;
        end else begin
            auth_s1_ff <= {ROOT_NONINVASIVE_FIELD, REALM_NONINVASIVE_FIELD,
                SECURE_NONINVASIVE_FIELD, NONSECURE_NONINVASIVE_FIELD};
            auth_s2_ff <= auth_s1_ff;
        end
    end

    // Answer registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
            ready_ff <= DBG_SEL;
        end
    end

    assign DBG_RDATA = rdata_ff;
    assign DBG_ERR = err_ff;
    assign DBG_READY = ready_ff;

    // Assertions
    // Helper terms naming the state each check looks at
    wire in_sec = CUR_SEC == PMCF_SEC; // Secure state
    wire in_nsec = CUR_SEC == PMCF_NSEC; // Non-secure state
    wire in_realm = CUR_SEC == PMCF_REALM; // Realm state
    wire at_el0 = CUR_EL == PMCF_EL0; // Running at EL0
    wire at_el1 = CUR_EL == PMCF_EL1; // Running at EL1
    wire at_el2 = CUR_EL == PMCF_EL2; // Running at EL2
    wire at_el3 = CUR_EL == PMCF_EL3; // Running at EL3

    // Counter held over one cycle
    sequence s_cnt_hold;
        CYCLE_COUNTER == $past(CYCLE_COUNTER);
    endsequence
    // Counter stepped by one over one cycle
    sequence s_cnt_step;
        CYCLE_COUNTER == $past(CYCLE_COUNTER) + 64'h1;
    endsequence
    // An answer that carries no error
    sequence s_answer_ok;
        DBG_READY && !DBG_ERR;
    endsequence
    // An answer that refuses the access and returns zero
    sequence s_answer_err;
        DBG_READY && DBG_ERR && DBG_RDATA == 32'h0000_0000;
    endsequence

    // Every request is answered on the next edge, and only then
    a_ready_follows: assert property (@(posedge CLK) disable iff (!RST_N)
        DBG_SEL |=> DBG_READY)
        else $error("request not answered");
    a_ready_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        !DBG_SEL |=> !DBG_READY && !DBG_ERR)
        else $error("answer without request");
    // Filter access answers
    a_filter_open_ok: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && filter_open |=> s_answer_ok)
        else $error("open filter access refused");
    a_filter_closed_keep: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && !filter_open |=> s_answer_err ##0 $stable(filter_ff))
        else $error("closed filter access misbehaved");
    a_filter_read_data: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && filter_open |=> DBG_RDATA == $past(filter_view))
        else $error("filter read data wrong");
    // A write under the soft lock is ignored without an error
    a_soft_lock_ok: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && DBG_WR && SOFT_LOCK && filter_open |=> s_answer_ok)
        else $error("soft locked write refused");
    // Reserved and absent bits never hold a one
    a_filter_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (filter_ff & ~WR_MASK) == 32'h0000_0000)
        else $error("reserved filter bit set");
    // Secure EL2 bit reads zero while secure EL2 is disabled
    a_sel2_hidden: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && filter_open && !SEL2_ENABLED |=> !DBG_RDATA[S_EL2_BIT])
        else $error("secure EL2 bit visible");
    // Status register answers
    a_auth_open_ok: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && auth_open |=> s_answer_ok)
        else $error("open status access refused");
    a_auth_closed_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && !auth_open |=> s_answer_err)
        else $error("closed status access misbehaved");
    a_auth_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth |=> DBG_RDATA[31:28] == 4'h0 && DBG_RDATA[23:16] == 8'h00
        && DBG_RDATA[11:8] == 4'h0)
        else $error("status reserved bits nonzero");
    // Mirrors of the other three noninvasive fields
    a_auth_root_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && auth_open |=> DBG_RDATA[27:26] == $past(auth_s2_ff[7:6]))
        else $error("root noninvasive mismatch");
    a_auth_realm_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && auth_open |=> DBG_RDATA[15:14] == $past(auth_s2_ff[5:4]))
        else $error("realm noninvasive mismatch");
    a_auth_nsec_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && auth_open |=> DBG_RDATA[3:2] == $past(auth_s2_ff[1:0]))
        else $error("nonsecure noninvasive mismatch");
    // Offsets outside the two registers are refused
    a_unmapped_err: assert property (@(posedge CLK) disable iff (!RST_N)
        DBG_SEL && !hit_filter && !hit_auth |=> s_answer_err)
        else $error("unmapped access not refused");

    // Filter verdicts per level and state
    a_el0_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el0 && in_sec && f[EL0_EXCL_BIT] |=> s_cnt_hold)
        else $error("counted in excluded EL0");
    a_ns_el1_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el1 && in_nsec && HAS_EL3 && f[NS_EL1_BIT] != f[EL1_EXCL_BIT]
        |=> s_cnt_hold)
        else $error("counted in filtered nonsecure EL1");
    a_ns_el0_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el0 && in_nsec && HAS_EL3 && f[NS_EL0_BIT] != f[EL0_EXCL_BIT]
        |=> s_cnt_hold)
        else $error("counted in filtered nonsecure EL0");
    a_el2_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el2 && in_nsec && !f[EL2_EN_BIT] |=> s_cnt_hold)
        else $error("counted in disabled EL2");
    a_el3_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el3 && HAS_EL3 && f[EL3_BIT] == f[EL1_EXCL_BIT]
        |=> s_cnt_step)
        else $error("EL3 cycle missed");
    a_sec_el2_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el2 && in_sec && HAS_SEL2 && HAS_EL3 && f[S_EL2_BIT] == f[EL2_EN_BIT]
        |=> s_cnt_hold)
        else $error("counted in filtered secure EL2");
    a_realm_el1_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el1 && in_realm && HAS_RME && f[RL_EL1_BIT] != f[EL1_EXCL_BIT]
        |=> s_cnt_hold)
        else $error("counted in filtered realm EL1");
    a_realm_el0_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el0 && in_realm && HAS_RME && f[RL_EL0_BIT] != f[EL0_EXCL_BIT]
        |=> s_cnt_hold)
        else $error("counted in filtered realm EL0");
    a_realm_el2_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        at_el2 && in_realm && HAS_RME && f[RL_EL2_BIT] == f[EL2_EN_BIT]
        |=> s_cnt_hold)
        else $error("counted in filtered realm EL2");
    // The counter follows the combined verdict exactly
    a_count_gated: assert property (@(posedge CLK) disable iff (!RST_N)
        !pass |=> s_cnt_hold)
        else $error("counter stepped on a filtered cycle");
    a_count_steps: assert property (@(posedge CLK) disable iff (!RST_N)
        pass |=> s_cnt_step)
        else $error("counter missed a passing cycle");

    // First edge after reset sees the filter at its reset value
    a_reset_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        !rst_seen_ff |-> filter_ff == FILTER_RESET_VAL)
        else $error("filter not at reset value");
    a_reset_32bit_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        !rst_seen_ff && RST_32BIT |-> filter_ff == 32'h0000_0000)
        else $error("filter not cleared by 32-bit reset");

    a_filter_err_closed: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && !filter_open |=> DBG_ERR && DBG_READY)
        else $error("filter access not refused");
    a_filter_ro_locked: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_filter && DBG_WR && SOFT_LOCK |=> $stable(filter_ff))
        else $error("filter written under soft lock");
    a_filter_write_lands: assert property (@(posedge CLK) disable iff (!RST_N)
        filter_wr |=> filter_ff == ($past(DBG_WDATA) & WR_MASK))
        else $error("filter write wrong");
    a_auth_err_off: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && !auth_open |=> DBG_ERR)
        else $error("auth access not refused");
    a_auth_invasive_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth |=> DBG_RDATA[25:24] == 2'b00 && DBG_RDATA[13:12] == 2'b00
        && DBG_RDATA[5:4] == 2'b00 && DBG_RDATA[1:0] == 2'b00)
        else $error("invasive field nonzero");
    a_auth_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
        hit_auth && auth_open |=> DBG_RDATA[7:6] == $past(auth_s2_ff[3:2]))
        else $error("secure noninvasive mismatch");
    a_el1_blocked: assert property (@(posedge CLK) disable iff (!RST_N)
        CUR_EL == PMCF_EL1 && CUR_SEC == PMCF_SEC && f[EL1_EXCL_BIT]
        |=> CYCLE_COUNTER == $past(CYCLE_COUNTER))
        else $error("counted in excluded EL1");
    a_el2_counts: assert property (@(posedge CLK) disable iff (!RST_N)
        HAS_EL2 && CUR_EL == PMCF_EL2 && CUR_SEC == PMCF_NSEC && f[EL2_EN_BIT]
        |=> CYCLE_COUNTER == $past(CYCLE_COUNTER) + 64'h1)
        else $error("EL2 cycle missed");
    a_extrst_keeps: assert property (@(posedge CLK) disable iff (!RST_N)
        EXT_DBG_RST && !filter_wr |=> $stable(filter_ff))
        else $error("filter disturbed by debug reset");
endmodule

// ==== verification/pmcf_dbg_model.sv ====
// External debugger model that issues single-word requests on the debug port.
// Assumes requests launch at the falling edge and the answer comes one edge later.
module pmcf_dbg_model (
    input wire logic CLK,
    output logic SEL,
    output logic WR,
    output logic [11:0] ADDR,
    output logic [31:0] WDATA,
    input wire logic [31:0] RDATA,
    input wire logic ERR,
    input wire logic READY
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        SEL = 1'b0;
        WR = 1'b0;
        ADDR = 12'h000;
        WDATA = 32'h0000_0000;
    end
    // One request: select for one edge, take the answer, then release
    task automatic xfer(input logic wr_i, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(negedge CLK);
        SEL = 1'b1;
        WR = wr_i;
        ADDR = a;
        WDATA = d;
        @(negedge CLK);
        SEL = 1'b0;
        // A missing answer turns the read data unknown so the compare fails
        rd = (READY === 1'b1) ? RDATA : {32{1'bx}};
        er = ERR;
        // Released lines must not keep showing the last value
        ADDR = ~a;
        WDATA = ~d;
    endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the filter and authentication status bank.
// Assumes default feature parameters and the debugger model as requester.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmcf_pkg::*;
    logic clk = 1'b0;
    logic rst_n, rst_32bit, ext_dbg_rst, core_powered, double_lock, os_lock;
    logic ext_access_ok, soft_lock, sel2_enabled;
    logic [1:0] rt_f, rl_f, s_f, ns_f; // Noninvasive pins
    pmcf_el_t cur_el;
    pmcf_sec_t cur_sec;
    wire logic sel, wr, err, ready;
    wire logic [11:0] addr;
    wire logic [31:0] wdata, rdata;
    wire logic [CNT_W-1:0] cnt;
    int errors = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic er;
    logic [CNT_W-1:0] c0;
    localparam logic [31:0] AUTH_EXP = 32'h0400_80C4; // Mirror of the pins below
    localparam logic [11:0] FO = CYCLE_COUNT_FILTER_OFS;
    localparam logic [11:0] AO = MONITOR_AUTH_STATUS_OFS;
    // Clock, 5 ns period
    always #2.5 clk = ~clk;
    pmcf_regs pmcf_regs_inst (.CLK(clk), .RST_N(rst_n), .RST_32BIT(rst_32bit),
        .EXT_DBG_RST(ext_dbg_rst), .CORE_POWERED(core_powered), .DOUBLE_LOCK(double_lock),
        .OS_LOCK(os_lock), .EXT_ACCESS_OK(ext_access_ok), .SOFT_LOCK(soft_lock),
        .SEL2_ENABLED(sel2_enabled), .ROOT_NONINVASIVE_FIELD(rt_f),
        .REALM_NONINVASIVE_FIELD(rl_f), .SECURE_NONINVASIVE_FIELD(s_f),
        .NONSECURE_NONINVASIVE_FIELD(ns_f), .CUR_EL(cur_el), .CUR_SEC(cur_sec),
        .DBG_SEL(sel), .DBG_WR(wr), .DBG_ADDR(addr), .DBG_WDATA(wdata),
        .DBG_RDATA(rdata), .DBG_ERR(err), .DBG_READY(ready), .CYCLE_COUNTER(cnt));
    pmcf_dbg_model pmcf_dbg_model_inst (.CLK(clk), .SEL(sel), .WR(wr), .ADDR(addr),
        .WDATA(wdata), .RDATA(rdata), .ERR(err), .READY(ready));
    // Read and compare data and error flag
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
        pmcf_dbg_model_inst.xfer(1'b0, a, 32'h0000_0000, rd, er);
        `CHK(rd, e)
        `CHK(er, ee)
    endtask
    // Write and compare the error flag
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic ee);
        pmcf_dbg_model_inst.xfer(1'b1, a, d, rd, er);
        `CHK(er, ee)
    endtask
    // Program the filter, hold a state for 10 cycles, compare the count step over the last 8
    task automatic run_case(input logic [31:0] f, input pmcf_el_t el, input pmcf_sec_t sc,
                            input logic on);
        wr_chk(FO, f, 1'b0);
        cur_el = el;
        cur_sec = sc;
        repeat (2) @(negedge clk);
        c0 = cnt;
        repeat (8) @(negedge clk);
        `CHK(cnt - c0, on ? 64'h0000_0000_0000_0008 : 64'h0000_0000_0000_0000)
    endtask
    // Verdict and end of run
    task automatic results();
        $display("tests_run=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
    // Main sequence
    initial begin
        {rst_n, rst_32bit, ext_dbg_rst, double_lock, os_lock, soft_lock} = 6'h00;
        {core_powered, ext_access_ok, sel2_enabled} = 3'h7;
        {rt_f, rl_f, s_f, ns_f} = 8'h6D;
        cur_el = PMCF_EL0;
        cur_sec = PMCF_SEC;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd_chk(FO, 32'h0000_0000, 1'b0);
        rd_chk(AO, AUTH_EXP, 1'b0);
        wr_chk(AO, 32'hFFFF_FFFF, 1'b0);
        rd_chk(AO, AUTH_EXP, 1'b0);
        $display("test reset and auth done");
        wr_chk(FO, 32'hFFFF_FFFF, 1'b0);
        rd_chk(FO, 32'hFD70_0000, 1'b0);
        sel2_enabled = 1'b0;
        rd_chk(FO, 32'hFC70_0000, 1'b0);
        sel2_enabled = 1'b1;
        soft_lock = 1'b1;
        wr_chk(FO, 32'h0000_0000, 1'b0);
        rd_chk(FO, 32'hFD70_0000, 1'b0);
        soft_lock = 1'b0;
        ext_dbg_rst = 1'b1;
        rd_chk(FO, 32'hFD70_0000, 1'b0);
        ext_dbg_rst = 1'b0;
        $display("test filter access done");
        for (int i = 0; i < 4; i++) begin
            core_powered = (i != 0);
            double_lock = (i == 1);
            os_lock = (i == 2);
            ext_access_ok = (i != 3);
            rd_chk(FO, 32'h0000_0000, 1'b1);
            rd_chk(AO, (i == 0) ? 32'h0000_0000 : AUTH_EXP, i == 0);
        end
        {core_powered, double_lock, os_lock, ext_access_ok} = 4'h9;
        rd_chk(12'h000, 32'h0000_0000, 1'b1);
        $display("test refusals done");
        run_case(32'h0000_0000, PMCF_EL1, PMCF_NSEC, 1'b1);
        run_case(32'h8000_0000, PMCF_EL1, PMCF_SEC, 1'b0);
        run_case(32'hA000_0000, PMCF_EL1, PMCF_NSEC, 1'b1);
        run_case(32'h2000_0000, PMCF_EL1, PMCF_NSEC, 1'b0);
        run_case(32'h4000_0000, PMCF_EL0, PMCF_SEC, 1'b0);
        run_case(32'h0000_0000, PMCF_EL0, PMCF_NSEC, 1'b1);
        run_case(32'h1000_0000, PMCF_EL0, PMCF_NSEC, 1'b0);
        run_case(32'h0800_0000, PMCF_EL2, PMCF_NSEC, 1'b1);
        run_case(32'h0000_0000, PMCF_EL2, PMCF_NSEC, 1'b0);
        run_case(32'h0000_0000, PMCF_EL3, PMCF_ROOT, 1'b1);
        run_case(32'h0400_0000, PMCF_EL3, PMCF_ROOT, 1'b0);
        run_case(32'h0800_0000, PMCF_EL2, PMCF_SEC, 1'b1);
        run_case(32'h0900_0000, PMCF_EL2, PMCF_SEC, 1'b0);
        run_case(32'h0000_0000, PMCF_EL1, PMCF_REALM, 1'b1);
        run_case(32'h0040_0000, PMCF_EL1, PMCF_REALM, 1'b0);
        run_case(32'h0020_0000, PMCF_EL0, PMCF_REALM, 1'b0);
        run_case(32'h0800_0000, PMCF_EL2, PMCF_REALM, 1'b1);
        run_case(32'h0810_0000, PMCF_EL2, PMCF_REALM, 1'b0);
        $display("test counting done");
        // Reset in mid-run toward a 32-bit target clears the written filter
        rst_32bit = 1'b1;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(cnt, 64'h0000_0000_0000_0000)
        rd_chk(FO, 32'h0000_0000, 1'b0);
        rd_chk(AO, AUTH_EXP, 1'b0);
        $display("test midrun reset done");
        results();
    end
endmodule
